// *** hdl/cpig_pkg.sv ***
package cpig_pkg;

	// Register indices as printed; the byte address is four times the index.
	localparam logic [7:0] CPIG_IDX_CTRL_B0 = 8'h0B;
	localparam logic [7:0] CPIG_IDX_CTRL_B1 = 8'h8B;
	localparam logic [7:0] CPIG_IDX_PFLAG = 8'h0C;
	localparam logic [7:0] CPIG_IDX_PEN = 8'h8C;
	// Extra registers for the system-level event status and mask.
	localparam logic [7:0] CPIG_IDX_EVT_STAT = 8'hF0;
	localparam logic [7:0] CPIG_IDX_EVT_MASK = 8'hF1;
	localparam int CPIG_ADDR_LSB = 2;

	// Interrupt control register bit positions.
	localparam int CPIG_CTRL_GIE = 7;
	localparam int CPIG_CTRL_PERIPHERAL_GROUP_ENABLE = 6;
	localparam int CPIG_CTRL_T0E = 5;
	localparam int CPIG_CTRL_EPE = 4;
	localparam int CPIG_CTRL_PCE = 3;
	localparam int CPIG_CTRL_T0F = 2;
	localparam int CPIG_CTRL_EPF = 1;
	localparam int CPIG_CTRL_PCF = 0;

	// Peripheral enable and flag bit positions (shared layout).
	localparam int CPIG_PER_CONV = 6;
	localparam int CPIG_PER_CCMP = 2;
	localparam int CPIG_PER_T2 = 1;
	localparam int CPIG_PER_T1 = 0;
	localparam logic [7:0] CPIG_PER_IMPL_MASK = 8'h47;

	// Reset values; the port-change flag is undefined at power-on, taken as zero.
	localparam logic [7:0] CPIG_CTRL_RST = 8'h00;
	localparam logic [7:0] CPIG_PER_RST = 8'h00;

	// Source event strobes, one cycle each.
	typedef struct packed {
		logic timer0_ovf;
		logic edge_pin;
		logic port_change;
		logic conv_done;
		logic capture_compare;
		logic timer2_match;
		logic timer1_ovf;
	} cpig_events_t;

endpackage

// *** hdl/cpig_flag_bit.sv ***
`timescale 1ns/1ns
// Sticky flag: a hardware set wins over a same-cycle clear.
module cpig_flag_bit (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Set and software update.
	input wire logic set_i,
	input wire logic wr_i,
	input wire logic wdata_i,
	// Stored flag.
	output logic flag_o
);

	// Software may write either value; hardware set has priority.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (wr_i) begin
			flag_o <= wdata_i;
		end
	end

endmodule

// *** hdl/cpig_top.sv ***
`timescale 1ns/1ns
module cpig_top (
	// System.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Source events.
	input wire cpig_pkg::cpig_events_t events_i,
	// Requests.
	output logic core_irq_o,
	output logic sys_irq_o
);

	logic [7:0] ctrl_en;
	logic [7:0] pen;
	logic [7:0] pflag;
	logic t0f;
	logic epf;
	logic pcf;
	logic [6:0] evt_stat;
	logic [6:0] evt_mask;
	logic [7:0] idx;
	logic acc;
	logic wr;
	logic rd;
	logic hit_ctrl;
	logic hit_pen;
	logic hit_pflag;
	logic hit_stat;
	logic hit_mask;
	logic mapped;
	logic lane0;
	logic [7:0] wd;
	logic [7:0] ctrl_rd;
	logic [31:0] next_prdata;
	logic next_core_irq;
	logic [6:0] evt_vec;

	// Top bit of the register index within the byte address.
	localparam int CPIG_ADDR_LSB_HI = cpig_pkg::CPIG_ADDR_LSB + 7;

	// Zero-wait APB: every access completes in its first access cycle.
	assign idx = paddr_i[CPIG_ADDR_LSB_HI:cpig_pkg::CPIG_ADDR_LSB];
	assign acc = psel_i && penable_i;
	assign lane0 = pstrb_i[0];
	assign wd = pwdata_i[7:0];
	assign wr = acc && pwrite_i && lane0;
	assign rd = acc && !pwrite_i;
	// Both bank aliases reach the same storage.
	assign hit_ctrl = (idx == cpig_pkg::CPIG_IDX_CTRL_B0) || (idx == cpig_pkg::CPIG_IDX_CTRL_B1);
	assign hit_pen = idx == cpig_pkg::CPIG_IDX_PEN;
	assign hit_pflag = idx == cpig_pkg::CPIG_IDX_PFLAG;
	assign hit_stat = idx == cpig_pkg::CPIG_IDX_EVT_STAT;
	assign hit_mask = idx == cpig_pkg::CPIG_IDX_EVT_MASK;
	assign mapped = hit_ctrl || hit_pen || hit_pflag || hit_stat || hit_mask;

	// Enable half of the control register: bits 7 to 3.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_en <= cpig_pkg::CPIG_CTRL_RST;
		end else if (wr && hit_ctrl) begin
			ctrl_en <= {wd[7:3], 3'h0};
		end
	end

	// Peripheral enables; unimplemented bits never store.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pen <= cpig_pkg::CPIG_PER_RST;
		end else if (wr && hit_pen) begin
			pen <= wd & cpig_pkg::CPIG_PER_IMPL_MASK;
		end
	end

	// Core flags: set by their events whatever the enables, cleared by software.
	cpig_flag_bit u_t0f (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.set_i(events_i.timer0_ovf),
		.wr_i(wr && hit_ctrl),
		.wdata_i(wd[cpig_pkg::CPIG_CTRL_T0F]),
		.flag_o(t0f)
	);
	cpig_flag_bit u_epf (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.set_i(events_i.edge_pin),
		.wr_i(wr && hit_ctrl),
		.wdata_i(wd[cpig_pkg::CPIG_CTRL_EPF]),
		.flag_o(epf)
	);
	cpig_flag_bit u_pcf (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.set_i(events_i.port_change),
		.wr_i(wr && hit_ctrl),
		.wdata_i(wd[cpig_pkg::CPIG_CTRL_PCF]),
		.flag_o(pcf)
	);

	// Peripheral flags share the enable layout; bits outside it stay zero.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pflag
			if (cpig_pkg::CPIG_PER_IMPL_MASK[gi]) begin : g_impl
				logic set_b;
				assign set_b = (gi == cpig_pkg::CPIG_PER_CONV) ? events_i.conv_done :
					(gi == cpig_pkg::CPIG_PER_CCMP) ? events_i.capture_compare :
					(gi == cpig_pkg::CPIG_PER_T2) ? events_i.timer2_match :
					events_i.timer1_ovf;
				cpig_flag_bit u_f (
					.clk_sys_i(clk_sys_i),
					.arst_n_i(arst_n_i),
					.set_i(set_b),
					.wr_i(wr && hit_pflag),
					.wdata_i(wd[gi]),
					.flag_o(pflag[gi])
				);
			end else begin : g_none
				assign pflag[gi] = 1'b0;
			end
		end
	endgenerate

	// Read view of the control register.
	assign ctrl_rd = {ctrl_en[7:3], t0f, epf, pcf};

	// The core request; software is expected to clear stale flags before enabling.
	always_comb begin
		next_core_irq = ctrl_en[cpig_pkg::CPIG_CTRL_GIE] && (
			(ctrl_en[cpig_pkg::CPIG_CTRL_T0E] && t0f) ||
			(ctrl_en[cpig_pkg::CPIG_CTRL_EPE] && epf) ||
			(ctrl_en[cpig_pkg::CPIG_CTRL_PCE] && pcf) ||
			(ctrl_en[cpig_pkg::CPIG_CTRL_PERIPHERAL_GROUP_ENABLE] && |(pen & pflag)));
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			core_irq_o <= 1'b0;
		end else begin
			core_irq_o <= next_core_irq;
		end
	end

	// System status: every source event is latched; reading clears, set wins.
	// Only bits that the read reported are cleared, so an event that lands at the
	// setup edge, after the read data were taken, is not lost.
	assign evt_vec = {events_i.timer0_ovf, events_i.edge_pin, events_i.port_change,
		events_i.conv_done, events_i.capture_compare, events_i.timer2_match,
		events_i.timer1_ovf};

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			evt_stat <= 7'h00;
		end else if (rd && hit_stat) begin
			evt_stat <= (evt_stat & ~prdata_o[6:0]) | evt_vec;
		end else begin
			evt_stat <= evt_stat | evt_vec;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			evt_mask <= 7'h00;
		end else if (wr && hit_mask) begin
			evt_mask <= wd[6:0];
		end
	end

	// Level output, high while an unmasked status bit stands.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sys_irq_o <= 1'b0;
		end else begin
			sys_irq_o <= |(evt_stat & evt_mask);
		end
	end

	// Read mux; unmapped addresses read zero and answer with an error.
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_ctrl) begin
			next_prdata = {24'h00_0000, ctrl_rd};
		end else if (hit_pen) begin
			next_prdata = {24'h00_0000, pen};
		end else if (hit_pflag) begin
			next_prdata = {24'h00_0000, pflag};
		end else if (hit_stat) begin
			next_prdata = {25'h000_0000, evt_stat};
		end else if (hit_mask) begin
			next_prdata = {25'h000_0000, evt_mask};
		end
	end

	// Registered answer held during the access phase; pready pulses one cycle.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i) begin
			pready_o <= 1'b1;
			pslverr_o <= !mapped;
			prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

endmodule

// *** tb/cpig_chk.sv ***
`timescale 1ns/1ns
// Shadows of the written bytes give the gating that each request must follow.
module cpig_chk (
	// System.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Bus.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Sources and requests.
	input wire cpig_pkg::cpig_events_t events_i,
	input wire logic core_irq_o,
	input wire logic sys_irq_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	logic [7:0] ctrl;
	logic [6:0] mask;
	wire done = psel_i && penable_i && pready_o;
	wire wr = done && pwrite_i && pstrb_i[0];
	wire wr_ctrl = wr && paddr_i inside {12'h02C, 12'h22C};
	wire wr_mask = wr && paddr_i == 12'h3C4;
	wire rd_st = psel_i && !pwrite_i && paddr_i == 12'h3C0;
	wire mapped = paddr_i inside {12'h02C, 12'h22C, 12'h030, 12'h230, 12'h3C0, 12'h3C4};
	// Flag bits are shadowed loosely; only the enables are used.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl <= 8'h00;
			mask <= 7'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl <= pwdata_i[7:0];
			end
			if (wr_mask) begin
				mask <= pwdata_i[6:0];
			end
		end
	end
	// A status read or mask write in the window may rightly hide the event.
	sequence calm_s;
		!rd_st && !wr_mask ##1 !rd_st && !wr_mask;
	endsequence
	a_ready_first: assert property (psel_i && penable_i && !$past(penable_i) |-> pready_o)
		else $error("pready missing");
	a_ready_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("pready outside access");
	a_enable_zero: assert property (done && !pwrite_i && paddr_i == 12'h230 |-> !(|(prdata_o & 32'hB8)))
		else $error("reserved enable bits set");
	a_upper_zero: assert property (done && !pwrite_i |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_map_err: assert property (done && !mapped |-> pslverr_o)
		else $error("no error on unmapped");
	a_map_ok: assert property (done && mapped |-> !pslverr_o)
		else $error("error on mapped");
	a_global_gate: assert property (core_irq_o |-> ctrl[7] || $past(ctrl[7]))
		else $error("request without global enable");
	a_sys_raise: assert property (|(events_i & mask) ##0 calm_s |-> ##1 sys_irq_o)
		else $error("event request late");
	a_sys_mask: assert property (sys_irq_o |-> mask != 7'h00 || $past(mask) != 7'h00)
		else $error("request while masked");
endmodule
bind cpig_top cpig_chk chk_u (.clk_sys_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .events_i, .core_irq_o, .sys_irq_o);

// *** tb/cpig_core_model.sv ***
`timescale 1ns/1ns
// Stand-in for the core: it takes a request once per rising level.
module cpig_core_model (
	// System.
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Request and taken count.
	input wire logic irq_i,
	output logic [7:0] taken_o
);
	logic seen;
	// A level held high is one request, not one per cycle.
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			seen <= 1'b0;
			taken_o <= 8'h00;
		end else begin
			seen <= irq_i;
			taken_o <= taken_o + {7'h00, irq_i && !seen};
		end
	end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ns
// Drives the bus, pulses random events and checks reads and both requests.
module tb;
	logic clk_sys_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rng = 32'hC8AD;
	logic [3:0] pstrb_i = 4'hF;
	logic pready_o, pslverr_o, core_irq_o, sys_irq_o;
	cpig_pkg::cpig_events_t events_i = 7'h00;
	logic [7:0] taken;
	logic [32:0] exp_q[$];
	logic [11:0] adr[6] = '{12'h02C, 12'h22C, 12'h030, 12'h230, 12'h3C0, 12'h3C4};
	int fails, checks, nirq;
	cpig_top dut_u (.clk_sys_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.pstrb_i, .prdata_o, .pready_o, .pslverr_o, .events_i, .core_irq_o, .sys_irq_o);
	cpig_core_model core_u (.clk_sys_i, .arst_n_i, .irq_i(core_irq_o), .taken_o(taken));
	task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	// Xorshift step for the random stimulus.
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction
	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// One transfer; a read leaves its expected error and data for the monitor.
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		if (!w) begin
			exp_q.push_back(e);
		end
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// Far beyond the expected run; a hang ends as a failure.
	initial begin
		#500000;
		fails++;
		wrap_up();
	end
	// Read results are compared at the edge where the master takes them.
	always @(posedge clk_sys_i) begin
		if (psel_i && penable_i && pready_o && !pwrite_i) begin
			chk("read", {pslverr_o, prdata_o}, exp_q.pop_front());
		end
	end
	initial begin
		logic [6:0] ev;
		logic [2:0] cf;
		logic [7:0] pf;
		logic want;
		repeat (12) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		foreach (adr[i]) apb(1'b0, adr[i], 8'h00, 33'h0);
		apb(1'b0, 12'h100, 8'h00, 33'h100000000);
		apb(1'b1, 12'h230, 8'hFF, 33'h0);
		apb(1'b0, 12'h230, 8'h00, 33'h47);
		repeat (8) begin
			rng = xs(rng);
			ev = rng[6:0];
			cf = ev[6:4];
			pf = {1'b0, ev[3], 3'h0, ev[2:0]};
			// Flags are cleared before the global enable goes on, so no stale request fires.
			apb(1'b1, 12'h02C, 8'h78, 33'h0);
			apb(1'b1, 12'h030, 8'h00, 33'h0);
			apb(1'b1, 12'h3C4, {1'b0, rng[14:8]}, 33'h0);
			@(posedge clk_sys_i);
			events_i <= ev;
			@(posedge clk_sys_i);
			events_i <= 7'h00;
			repeat (2) @(posedge clk_sys_i);
			chk("core_off", core_irq_o, 33'h0);
			chk("sys", sys_irq_o, {32'h0, |(ev & rng[14:8])});
			apb(1'b0, 12'h3C0, 8'h00, {26'h0, ev});
			apb(1'b0, 12'h3C0, 8'h00, 33'h0);
			apb(1'b0, 12'h02C, 8'h00, {30'h0, cf} | 33'h78);
			apb(1'b0, 12'h030, 8'h00, {25'h0, pf});
			apb(1'b1, 12'h22C, {1'b1, rng[16], 3'h7, cf}, 33'h0);
			repeat (2) @(posedge clk_sys_i);
			want = |cf || (rng[16] && |pf);
			nirq += want;
			chk("core", core_irq_o, {32'h0, want});
		end
		// The model counts at the edge after the request rises; let it settle.
		@(posedge clk_sys_i);
		chk("taken", {25'h0, taken}, nirq);
		wrap_up();
	end
endmodule
